// *** hw/flash_bus_cycle.sv ***
`timescale 1ns/1ns
`include "flash_host_consts.svh"

// Runs one asynchronous read or write cycle on the device pins
module flash_bus_cycle
	import flash_host_pkg::*;
#(
	parameter int PHASE_CYC = `FH_PHASE_CYC
)
(
	// Clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_b,
	// Cycle request
	input  wire logic        i_start,
	input  wire bus_cyc_s    i_cyc,
	output logic             o_done,
	output logic [7:0]       o_rdata,
	// Device pins
	output flash_pins_s      o_pins,
	input  wire logic [7:0]  i_data_in
);

	typedef enum logic [3:0]
	{
		C_IDLE  = 4'h1,
		C_SETUP = 4'h2,
		C_STRB  = 4'h4,
		C_HOLD  = 4'h8
	} cyc_st_e;

	typedef struct packed
	{
		cyc_st_e     st;
		logic [7:0]  cnt;
		logic        done;
		logic [7:0]  rdata;
		flash_pins_s pins;
	} cyc_state_s;

	cyc_state_s cur_ff;
	cyc_state_s nxt_cur;

	// ****************************************
	// Strobe sequencer
	// ****************************************

	// Chip select opens, strobe pulses, then everything releases, so no contention
	always_comb
	begin
		nxt_cur = cur_ff;
		nxt_cur.done = 1'b0;
		unique case (cur_ff.st)
			C_IDLE:
			begin
				if (i_start)
				begin
					nxt_cur.st = C_SETUP;
					nxt_cur.cnt = 8'(PHASE_CYC);
					nxt_cur.pins.ce_b = 1'b0;
					nxt_cur.pins.addr = i_cyc.addr;
					nxt_cur.pins.data_out = i_cyc.data;
					nxt_cur.pins.data_oe = i_cyc.wr; // Drive only on writes
				end
			end
			C_SETUP:
			begin
				nxt_cur.st = C_STRB;
				nxt_cur.cnt = 8'(PHASE_CYC);
				if (nxt_cur.pins.data_oe)
					nxt_cur.pins.we_b = 1'b0;
				else
					nxt_cur.pins.oe_b = 1'b0;
			end
			C_STRB:
			begin
				if (cur_ff.cnt > 8'h01)
					nxt_cur.cnt = cur_ff.cnt - 8'h01;
				else
				begin
					nxt_cur.st = C_HOLD;
					nxt_cur.rdata = i_data_in; // Sample before output enable drops
					nxt_cur.pins.we_b = 1'b1;
					nxt_cur.pins.oe_b = 1'b1;
				end
			end
			C_HOLD:
			begin
				nxt_cur.st = C_IDLE;
				nxt_cur.done = 1'b1;
				nxt_cur.pins.ce_b = 1'b1;
				nxt_cur.pins.data_oe = 1'b0;
			end
		endcase
	end

	// State register
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_b)
		begin
			cur_ff <= '{st: C_IDLE, cnt: 8'h00, done: 1'b0, rdata: 8'h00,
				pins: '{ce_b: 1'b1, we_b: 1'b1, oe_b: 1'b1, addr: 19'h00000,
				data_out: 8'h00, data_oe: 1'b0}};
		end
		else
		begin
			cur_ff <= nxt_cur;
		end
	end

	assign o_done  = cur_ff.done;
	assign o_rdata = cur_ff.rdata;
	assign o_pins  = cur_ff.pins;

endmodule : flash_bus_cycle

// *** hw/flash_host_consts.svh ***
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH

// Array geometry
`define FH_ADDR_W        19
`define FH_DATA_W        8
`define FH_SECT_CNT      8
`define FH_SECT_MSB      18
`define FH_SECT_LSB      16

// Unlock sequence addresses and data
`define FH_UNLOCK_A1     19'h00555
`define FH_UNLOCK_A2     19'h002aa
`define FH_UNLOCK_D1     8'haa
`define FH_UNLOCK_D2     8'h55

// Command codes
`define FH_CMD_PROG      8'ha0
`define FH_CMD_ERASE     8'h80
`define FH_CMD_CHIP      8'h10
`define FH_CMD_SECT      8'h30
`define FH_CMD_SUSP      8'hb0
`define FH_CMD_RESUME    8'h30
`define FH_CMD_BYP       8'h20
`define FH_CMD_BYP_X1    8'h90
`define FH_CMD_BYP_X2    8'h00
`define FH_CMD_RESET     8'hf0

// Status bit positions
`define FH_POLL_BIT      7
`define FH_TOGGLE_BIT    6

// Bus timing: strobe phase length in ns, cycles derived at 20 MHz
`define FH_CLK_NS        50
`define FH_PHASE_NS      100
`define FH_PHASE_CYC     ((`FH_PHASE_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)

`endif

// *** hw/flash_host_ctrl.sv ***
`timescale 1ns/1ns
`include "flash_host_consts.svh"

// Function
// - Separate chip select, write, output enable
// - Commands are plain write cycles
// - Bypass program takes two writes
// - Poll toggle bit 6; bit 7 is not polled
// - Deselect gives standby
module flash_host_ctrl
	import flash_host_pkg::*;
#(
	parameter int ADDR_W    = `FH_ADDR_W,
	parameter int PHASE_CYC = `FH_PHASE_CYC
)
(
	// Clock and reset
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst_b,
	// User request
	input  wire logic              i_req,
	input  wire flash_op_e         i_op,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [7:0]        i_wdata,
	output logic                   o_busy,
	output logic                   o_done,
	output logic                   o_err,
	output logic [7:0]             o_rdata,
	// Device pins
	output logic                   o_ce_b,
	output logic                   o_we_b,
	output logic                   o_oe_b,
	output logic [ADDR_W-1:0]      o_addr,
	output logic [7:0]             o_data_lines_out,
	output logic                   o_data_lines_oe,
	input  wire logic [7:0]        i_data_lines_in
);

	typedef enum logic [4:0]
	{
		S_IDLE = 5'h01,
		S_SEQ  = 5'h02,
		S_WAIT = 5'h04,
		S_POLL = 5'h08,
		S_FIN  = 5'h10
	} ctrl_st_e;

	typedef struct packed
	{
		ctrl_st_e   st;
		flash_op_e  op;
		logic [2:0] idx;
		logic [2:0] len;
		logic       bypass;
		logic       have_prev;
		logic [7:0] prev;
		logic [18:0] addr;
		logic [7:0] wdata;
		logic       busy;
		logic       done;
		logic       err;
		logic [7:0] rdata;
	} ctrl_state_s;

	ctrl_state_s cur_ff;
	ctrl_state_s nxt_cur;
	logic        cyc_start;
	bus_cyc_s    cyc;
	logic        cyc_done;
	logic [7:0]  cyc_rdata;
	flash_pins_s pins;

	// ****************************************
	// Command sequence tables
	// ****************************************

	// Number of bus writes for each operation; bypass program needs only two
	function automatic logic [2:0] seq_len(input flash_op_e op, input logic byp);
		unique case (op)
			OP_PROG:   seq_len = byp ? 3'd2 : 3'd4;
			OP_SECT:   seq_len = 3'd6;
			OP_CHIP:   seq_len = 3'd6;
			OP_BYP_ON: seq_len = 3'd3;
			OP_BYP_OFF:seq_len = 3'd2;
			OP_READ:   seq_len = 3'd0;
			default:   seq_len = 3'd1;
		endcase
	endfunction : seq_len

	// Write cycle number n of the sequence for op
	function automatic bus_cyc_s seq_cyc(input flash_op_e op, input logic byp,
		input logic [2:0] n, input logic [18:0] a, input logic [7:0] d);
		bus_cyc_s c;
		c = '{wr: 1'b1, addr: `FH_UNLOCK_A1, data: `FH_UNLOCK_D1};
		if (op == OP_PROG && byp)
			c = (n == 3'd0) ? bus_cyc_s'{1'b1, a, `FH_CMD_PROG} :
				bus_cyc_s'{1'b1, a, d};
		else if (op == OP_BYP_OFF)
			c = (n == 3'd0) ? bus_cyc_s'{1'b1, a, `FH_CMD_BYP_X1} :
				bus_cyc_s'{1'b1, a, `FH_CMD_BYP_X2};
		else if (op == OP_SUSP)
			c = '{1'b1, a, `FH_CMD_SUSP};
		else if (op == OP_RESUME)
			c = '{1'b1, a, `FH_CMD_RESUME};
		else if (op == OP_RESET)
			c = '{1'b1, a, `FH_CMD_RESET};
		else
		begin
			unique case (n)
				3'd0: c = '{1'b1, `FH_UNLOCK_A1, `FH_UNLOCK_D1};
				3'd1: c = '{1'b1, `FH_UNLOCK_A2, `FH_UNLOCK_D2};
				3'd2:
				begin
					c.addr = `FH_UNLOCK_A1;
					c.data = (op == OP_PROG) ? `FH_CMD_PROG :
						(op == OP_BYP_ON) ? `FH_CMD_BYP : `FH_CMD_ERASE;
				end
				3'd3: c = (op == OP_PROG) ? bus_cyc_s'{1'b1, a, d} :
					bus_cyc_s'{1'b1, `FH_UNLOCK_A1, `FH_UNLOCK_D1};
				3'd4: c = '{1'b1, `FH_UNLOCK_A2, `FH_UNLOCK_D2};
				default: c = (op == OP_CHIP) ?
					bus_cyc_s'{1'b1, `FH_UNLOCK_A1, `FH_CMD_CHIP} :
					bus_cyc_s'{1'b1, a, `FH_CMD_SECT};
			endcase
		end
		return c;
	endfunction : seq_cyc

	// ****************************************
	// Controller state machine
	// ****************************************

	// Sequences writes, then reads once, or for program, erase and resume polls the toggle bit until two reads agree
	always_comb
	begin
		nxt_cur = cur_ff;
		nxt_cur.done = 1'b0;
		cyc_start = 1'b0;
		cyc = seq_cyc(cur_ff.op, cur_ff.bypass, cur_ff.idx, cur_ff.addr, cur_ff.wdata);
		unique case (cur_ff.st)
			S_IDLE:
			begin
				if (i_req)
				begin
					nxt_cur.op = i_op;
					nxt_cur.addr = 19'(i_addr);
					nxt_cur.wdata = i_wdata;
					nxt_cur.idx = 3'd0;
					nxt_cur.len = seq_len(i_op, cur_ff.bypass);
					nxt_cur.busy = 1'b1;
					nxt_cur.err = 1'b0;
					nxt_cur.have_prev = 1'b0;
					nxt_cur.st = S_SEQ;
				end
			end
			S_SEQ:
			begin
				cyc_start = 1'b1;
				if (cur_ff.idx == cur_ff.len)
				begin
					// Reads, and polling after writes, use a read cycle
					cyc = '{wr: 1'b0, addr: cur_ff.addr, data: 8'h00};
					nxt_cur.st = S_POLL;
				end
				else
					nxt_cur.st = S_WAIT;
			end
			S_WAIT:
			begin
				if (cyc_done)
				begin
					nxt_cur.idx = cur_ff.idx + 3'd1;
					nxt_cur.st = S_SEQ;
				end
			end
			S_POLL:
			begin
				if (cyc_done)
				begin
					nxt_cur.rdata = cyc_rdata;
					nxt_cur.have_prev = 1'b1;
					nxt_cur.prev = cyc_rdata;
					if (cur_ff.op == OP_READ || cur_ff.op == OP_BYP_ON ||
						cur_ff.op == OP_BYP_OFF || cur_ff.op == OP_RESET ||
						cur_ff.op == OP_SUSP)
						nxt_cur.st = S_FIN;
					// Toggle stopped: algorithm finished, array data is back
					else if (cur_ff.have_prev &&
						cyc_rdata[`FH_TOGGLE_BIT] == cur_ff.prev[`FH_TOGGLE_BIT])
					begin
						nxt_cur.st = S_FIN;
						// Program read differs from the written data, or erase read is not 8'hff: refused
						if (cur_ff.op == OP_PROG)
							nxt_cur.err = (cyc_rdata != cur_ff.wdata);
						else if (cur_ff.op != OP_RESUME)
							nxt_cur.err = (cyc_rdata != 8'hff);
					end
					else
						nxt_cur.st = S_SEQ;
				end
			end
			S_FIN:
			begin
				if (cur_ff.op == OP_BYP_ON)
					nxt_cur.bypass = 1'b1;
				else if (cur_ff.op == OP_BYP_OFF || cur_ff.op == OP_RESET)
					nxt_cur.bypass = 1'b0;
				nxt_cur.busy = 1'b0;
				nxt_cur.done = 1'b1;
				nxt_cur.st = S_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_b)
		begin
			cur_ff <= '{st: S_IDLE, op: OP_READ, idx: 3'd0, len: 3'd0, bypass: 1'b0,
				have_prev: 1'b0, prev: 8'h00, addr: 19'h00000, wdata: 8'h00,
				busy: 1'b0, done: 1'b0, err: 1'b0, rdata: 8'h00};
		end
		else
		begin
			cur_ff <= nxt_cur;
		end
	end

	// ****************************************
	// Pin sequencer
	// ****************************************

	// One bus cycle engine; its pins come straight from its flops
	flash_bus_cycle #(
		.PHASE_CYC (PHASE_CYC)
	) u_cycle (
		.i_ref_clk (i_ref_clk),
		.i_rst_b   (i_rst_b),
		.i_start   (cyc_start),
		.i_cyc     (cyc),
		.o_done    (cyc_done),
		.o_rdata   (cyc_rdata),
		.o_pins    (pins),
		.i_data_in (i_data_lines_in)
	);

	// Outputs
	assign o_busy           = cur_ff.busy;
	assign o_done           = cur_ff.done;
	assign o_err            = cur_ff.err;
	assign o_rdata          = cur_ff.rdata;
	assign o_ce_b           = pins.ce_b;
	assign o_we_b           = pins.we_b;
	assign o_oe_b           = pins.oe_b;
	assign o_addr           = ADDR_W'(pins.addr);
	assign o_data_lines_out = pins.data_out;
	assign o_data_lines_oe  = pins.data_oe;

endmodule : flash_host_ctrl

// *** hw/flash_host_pkg.sv ***
package flash_host_pkg;

	// Operation requested by the user side
	typedef enum logic [3:0]
	{
		OP_READ   = 4'h0,
		OP_PROG   = 4'h1,
		OP_SECT   = 4'h2,
		OP_CHIP   = 4'h3,
		OP_SUSP   = 4'h4,
		OP_RESUME = 4'h5,
		OP_BYP_ON = 4'h6,
		OP_BYP_OFF= 4'h7,
		OP_RESET  = 4'h8
	} flash_op_e;

	// One bus cycle on the device pins
	typedef struct packed
	{
		logic        wr;
		logic [18:0] addr;
		logic [7:0]  data;
	} bus_cyc_s;

	// Device pin bundle driven by the host
	typedef struct packed
	{
		logic        ce_b;
		logic        we_b;
		logic        oe_b;
		logic [18:0] addr;
		logic [7:0]  data_out;
		logic        data_oe;
	} flash_pins_s;

endpackage : flash_host_pkg

// *** testbench/flash_dev_model.sv ***
`timescale 1ns/1ns
`include "flash_host_consts.svh"
// ****
// Device model
// ****
module flash_dev_model
#(
	parameter logic [7:0] PROT_MASK = 8'h04,
	parameter int         BUSY_RD   = 3,
	parameter int         SLEEP_NS  = 500
)
(
	// Controls and data lines
	input  wire logic        i_ce_b,
	input  wire logic        i_we_b,
	input  wire logic        i_oe_b,
	input  wire logic [18:0] i_addr,
	input  wire logic [7:0]  i_data,
	input  wire logic        i_low_supply,
	output logic [7:0]       o_data
);
	logic [7:0] mem [0:524287];
	logic [1:0] step = 2'h0;
	logic       ers  = 1'b0;
	logic       byp  = 1'b0;
	logic       xit  = 1'b0;
	logic       pb   = 1'b0;
	logic       tog  = 1'b0;
	logic [7:0] val;
	int         busy = 0;
	int         moves = 0;
	int         moves_seen;
	logic       asleep = 1'b0;
	// Shipped erased
	initial
	begin
		for (int i = 0; i < 524288; i++)
			mem[i] = 8'hff;
	end
	// Commands latch on the strobe's rising edge; busy ignores writes
	always @(posedge i_we_b)
	begin
		if (!i_ce_b && !i_low_supply && busy == 0)
		begin
			if (step == 2'h3)
			begin
				if (!PROT_MASK[i_addr[18:16]])
					mem[i_addr] = mem[i_addr] & i_data;
				pb = ~i_data[7];
				busy = BUSY_RD;
				step = 2'h0;
			end
			else if (xit)
			begin
				byp = i_data != `FH_CMD_BYP_X2;
				xit = 1'b0;
			end
			else if (step == 2'h2)
			begin
				step = (i_data == `FH_CMD_PROG) ? 2'h3 : 2'h0;
				byp = byp | (i_data == `FH_CMD_BYP);
				if (ers && (i_data == `FH_CMD_SECT || i_data == `FH_CMD_CHIP))
				begin
					for (int i = 0; i < 524288; i++)
						if ((i_data == `FH_CMD_CHIP || i[18:16] == i_addr[18:16])
							&& !PROT_MASK[i[18:16]])
							mem[i] = 8'hff;
					pb = 1'b0;
					busy = 2 * BUSY_RD;
				end
				ers = i_data == `FH_CMD_ERASE;
			end
			else if (byp && i_data == `FH_CMD_PROG)
				step = 2'h3;
			else if (byp && i_data == `FH_CMD_BYP_X1)
				xit = 1'b1;
			// Writes are refused while busy, so a suspend never finds an erase to pause
			else if (step == 2'h0 && i_data == `FH_CMD_SUSP)
				step = 2'h0;
			else if (i_addr == `FH_UNLOCK_A1 && i_data == `FH_UNLOCK_D1)
				step = 2'h1;
			else
				step = (step == 2'h1 && i_data == `FH_UNLOCK_D2) ? 2'h2 : 2'h0;
		end
	end
	// Released lines show the inverse so a stale value never passes
	always_comb
	begin
		val = (busy > 0) ? {pb, tog, 6'h00} : mem[i_addr];
		o_data = (!i_ce_b && !i_oe_b) ? val : ~val;
	end
	// Each status read advances the algorithm and flips the toggle bit
	always @(posedge i_oe_b)
	begin
		if (!i_ce_b && busy > 0)
		begin
			busy--;
			tog = ~tog;
		end
	end
	// Sleep after a whole quiet window of address; data stays readable
	always @(i_addr) moves++;
	always
	begin
		moves_seen = moves;
		#SLEEP_NS;
		asleep = (moves == moves_seen);
	end
endmodule : flash_dev_model

// *** testbench/flash_host_ctrl_props.sv ***
`timescale 1ns/1ns
// ****
// Pin checks
// ****
module flash_host_ctrl_props
#(
	parameter int PHASE_CYC = 2
)
(
	// Clock and user side
	input  wire logic i_ref_clk,
	input  wire logic i_rst_b,
	input  wire logic i_req,
	input  wire logic o_busy,
	input  wire logic o_done,
	// Device pins
	input  wire logic o_ce_b,
	input  wire logic o_we_b,
	input  wire logic o_oe_b,
	input  wire logic o_data_lines_oe
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_b);
	// Strobe phases open on a falling control
	sequence s_wr;
		$fell(o_we_b);
	endsequence
	sequence s_rd;
		$fell(o_oe_b);
	endsequence
	property p_excl;
		!o_oe_b |-> o_we_b && !o_ce_b;
	endproperty
	a_excl: assert property (p_excl) else $error("strobes overlap");
	property p_wr_drive;
		!o_we_b |-> o_data_lines_oe && !o_ce_b;
	endproperty
	a_wr_drive: assert property (p_wr_drive) else $error("write undriven");
	// Host must float the lines while the device may drive them
	property p_rd_float;
		!o_oe_b |-> !o_data_lines_oe;
	endproperty
	a_rd_float: assert property (p_rd_float) else $error("contention");
	property p_wr_len;
		s_wr |-> !o_we_b ##PHASE_CYC $rose(o_we_b);
	endproperty
	a_wr_len: assert property (p_wr_len) else $error("write phase length");
	property p_rd_len;
		s_rd |-> ##PHASE_CYC $rose(o_oe_b);
	endproperty
	a_rd_len: assert property (p_rd_len) else $error("read phase length");
	property p_take;
		i_req && !o_busy |=> o_busy;
	endproperty
	a_take: assert property (p_take) else $error("request lost");
	property p_done;
		o_done |-> !o_busy ##1 !o_done;
	endproperty
	a_done: assert property (p_done) else $error("done shape");
	// Idle host leaves the device deselected for standby
	property p_idle;
		!o_busy |-> o_ce_b && o_we_b && o_oe_b && !o_data_lines_oe;
	endproperty
	a_idle: assert property (p_idle) else $error("idle pins");
endmodule : flash_host_ctrl_props

bind flash_host_ctrl flash_host_ctrl_props #(.PHASE_CYC(PHASE_CYC)) props_i
(
	.i_ref_clk      (i_ref_clk),
	.i_rst_b        (i_rst_b),
	.i_req          (i_req),
	.o_busy         (o_busy),
	.o_done         (o_done),
	.o_ce_b         (o_ce_b),
	.o_we_b         (o_we_b),
	.o_oe_b         (o_oe_b),
	.o_data_lines_oe(o_data_lines_oe)
);

// *** testbench/tb_parallel_nor_flash_command_core.sv ***
`timescale 1ns/1ns
module tb_parallel_nor_flash_command_core
	import flash_host_pkg::*;
;
	logic        i_ref_clk = 1'b0;
	logic        i_rst_b   = 1'b0;
	logic        i_req     = 1'b0;
	flash_op_e   i_op      = OP_READ;
	logic [18:0] i_addr    = 19'h00000;
	logic [7:0]  i_wdata   = 8'h00;
	logic        low_supply = 1'b0;
	logic        o_busy, o_done, o_err, o_ce_b, o_we_b, o_oe_b, doe;
	logic [7:0]  o_rdata, dout, dev_q;
	logic [18:0] o_addr;
	wire  [7:0]  bus_w = doe ? dout : dev_q;
	int          n_fail = 0;
	int          compares = 0;
	int          nwe = 0;
	flash_host_ctrl flash_host_ctrl_i (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
		.i_req(i_req), .i_op(i_op), .i_addr(i_addr), .i_wdata(i_wdata),
		.o_busy(o_busy), .o_done(o_done), .o_err(o_err), .o_rdata(o_rdata),
		.o_ce_b(o_ce_b), .o_we_b(o_we_b), .o_oe_b(o_oe_b), .o_addr(o_addr),
		.o_data_lines_out(dout), .o_data_lines_oe(doe), .i_data_lines_in(bus_w));
	flash_dev_model flash_dev_model_i (.i_ce_b(o_ce_b), .i_we_b(o_we_b),
		.i_oe_b(o_oe_b), .i_addr(o_addr), .i_data(bus_w), .i_low_supply(low_supply),
		.o_data(dev_q));
	// Clock and write strobe count
	initial
	begin
		forever #25 i_ref_clk = ~i_ref_clk;
	end
	always @(negedge o_we_b) nwe++;
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// One request, bounded wait for done
	task automatic run(input flash_op_e op, input logic [18:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		#5;
		{i_req, i_op, i_addr, i_wdata} = {1'b1, op, a, d};
		@(posedge i_ref_clk);
		#5;
		i_req = 1'b0;
		for (int k = 0; k < 3000 && o_done !== 1'b1; k++)
			@(posedge i_ref_clk) #1;
		check("done", {7'h00, o_done}, 8'h01);
	endtask : run
	task automatic rd(input logic [18:0] a, input logic [7:0] exp);
		run(OP_READ, a, 8'h00);
		check("read", o_rdata, exp);
	endtask : rd
	task automatic t_prog();
		rd(19'h00000, 8'hff);
		rd(19'h7ffff, 8'hff);
		nwe = 0;
		run(OP_PROG, 19'h12345, 8'h5a);
		check("writes", nwe[7:0], 8'h04);
		check("err", {7'h00, o_err}, 8'h00);
		rd(19'h12345, 8'h5a);
		run(OP_PROG, 19'h12345, 8'h0f);
		rd(19'h12345, 8'h0a);
		run(OP_PROG, 19'h20010, 8'h00);
		check("prot err", {7'h00, o_err}, 8'h01);
		rd(19'h20010, 8'hff);
		$display("t_prog end");
	endtask : t_prog
	task automatic t_erase();
		run(OP_PROG, 19'h00100, 8'h33);
		run(OP_SECT, 19'h10000, 8'h00);
		rd(19'h12345, 8'hff);
		rd(19'h00100, 8'h33);
		$display("t_erase end");
	endtask : t_erase
	task automatic t_byp();
		run(OP_BYP_ON, 19'h00000, 8'h00);
		nwe = 0;
		run(OP_PROG, 19'h00200, 8'hc3);
		check("byp writes", nwe[7:0], 8'h02);
		rd(19'h00200, 8'hc3);
		run(OP_BYP_OFF, 19'h00000, 8'h00);
		nwe = 0;
		run(OP_PROG, 19'h00201, 8'h3c);
		check("writes", nwe[7:0], 8'h04);
		nwe = 0;
		run(OP_SUSP, 19'h00000, 8'h00);
		check("susp writes", nwe[7:0], 8'h01);
		rd(19'h00200, 8'hc3);
		run(OP_RESUME, 19'h00000, 8'h00);
		run(OP_RESET, 19'h00000, 8'h00);
		run(OP_CHIP, 19'h00000, 8'h00);
		rd(19'h00100, 8'hff);
		rd(19'h00201, 8'hff);
		$display("t_byp end");
	endtask : t_byp
	// Reset after bypass entry clears the host's bypass state; full unlock still programs
	task automatic t_reset();
		run(OP_BYP_ON, 19'h00000, 8'h00);
		@(posedge i_ref_clk);
		#5;
		i_rst_b = 1'b0;
		repeat (3) @(posedge i_ref_clk);
		#5;
		i_rst_b = 1'b1;
		check("rst busy", {7'h00, o_busy}, 8'h00);
		check("rst ce_b", {7'h00, o_ce_b}, 8'h01);
		nwe = 0;
		run(OP_PROG, 19'h00400, 8'h77);
		check("rst writes", nwe[7:0], 8'h04);
		rd(19'h00400, 8'h77);
		$display("t_reset end");
	endtask : t_reset
	// Low supply swallows the program, so the verify compare flags it
	task automatic t_low();
		@(posedge i_ref_clk);
		#5;
		low_supply = 1'b1;
		run(OP_PROG, 19'h00300, 8'h11);
		check("low err", {7'h00, o_err}, 8'h01);
		@(posedge i_ref_clk);
		#5;
		low_supply = 1'b0;
		rd(19'h00300, 8'hff);
		$display("t_low end");
	endtask : t_low
	// A quiet address puts the device to sleep without losing data
	task automatic t_sleep();
		rd(19'h00400, 8'h77);
		repeat (40) @(posedge i_ref_clk);
		check("sleep", {7'h00, flash_dev_model_i.asleep}, 8'h01);
		rd(19'h00400, 8'h77);
		$display("t_sleep end");
	endtask : t_sleep
	task automatic complete_run();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run
	initial
	begin
		repeat (12) @(posedge i_ref_clk);
		#5;
		i_rst_b = 1'b1;
		t_prog();
		t_erase();
		t_byp();
		t_reset();
		t_low();
		t_sleep();
		complete_run();
	end
	// Watchdog far beyond the expected run
	initial
	begin
		#2000000;
		n_fail++;
		complete_run();
	end
endmodule : tb_parallel_nor_flash_command_core
